// ===== design/exception_arbiter.sv
// fixed priority exception arbiter with vector lookup
`timescale 1ns/1ps
`default_nettype none
`include "opmode_params.svh"
module exception_arbiter (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // requests
  input wire logic i_hw_reset,
  input wire logic i_wd_reset,
  input wire logic [3:0] i_nmi,
  input wire logic i_ext_a,
  input wire logic i_ext_b,
  input wire logic [6:0] i_chan,
  input wire logic [15:0] i_ipr,
  // result
  output logic o_valid,
  output logic [15:0] o_vector
);
  // ---------------------------------------------------------------
  // priority search
  // ---------------------------------------------------------------
  logic [15:0] next_vector;
  logic next_valid;
  always_comb begin
    next_valid = 1'b1;
    next_vector = `VEC_HW_RESET;
    if (i_hw_reset) begin
      next_vector = `VEC_HW_RESET;
    end else if (i_wd_reset) begin
      next_vector = `VEC_WD_RESET;
    end else if (i_nmi[0]) begin
      next_vector = `VEC_ILLEGAL;
    end else if (i_nmi[1]) begin
      next_vector = `VEC_STACK;
    end else if (i_nmi[2]) begin
      next_vector = `VEC_EMU;
    end else if (i_nmi[3]) begin
      next_vector = `VEC_SWI;
    end else if (i_ext_a && (i_ipr[2:0] != 3'h0)) begin
      next_vector = `VEC_EXT_A;
    end else if (i_ext_b && (i_ipr[5:3] != 3'h0)) begin
      next_vector = `VEC_EXT_B;
    end else begin
      next_valid = 1'b0;
      for (int c = 6; c >= 0; c--) begin
        if (!next_valid && i_chan[c] && i_ipr[15 - c]) begin
          next_valid = 1'b1;
          next_vector = 16'(`VEC_PERIPH_BASE + 16'(2 * c));
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // registered result
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_valid <= 1'b0;
      o_vector <= 16'h0000;
    end else begin
      o_valid <= next_valid;
      o_vector <= next_vector;
    end
  end
  // reset always beats a non-maskable request
  a_reset_first: assert property (@(posedge i_clk) disable iff (i_srst)
    i_hw_reset |=> o_vector == `VEC_HW_RESET)
    else $error("hardware reset not first");
  a_wd_second: assert property (@(posedge i_clk) disable iff (i_srst)
    (!i_hw_reset && i_wd_reset) |=> o_vector == `VEC_WD_RESET)
    else $error("watchdog reset not second");
  a_ext_a_over: assert property (@(posedge i_clk) disable iff (i_srst)
    (!i_hw_reset && !i_wd_reset && i_nmi == 4'h0 && i_ext_a
     && i_ipr[2:0] != 3'h0) |=> o_vector == `VEC_EXT_A)
    else $error("external request a lost priority");
endmodule : exception_arbiter
`default_nettype wire

// ===== design/opmode_memory_map.sv
// operating mode, program memory map and data read checks
`timescale 1ns/1ps
`default_nettype none
`include "opmode_params.svh"
module opmode_memory_map (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wd_reset,
  // pins
  input wire logic i_boot_source_pin,
  // register port
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  // program fetch
  input wire logic i_fetch,
  input wire logic [15:0] i_fetch_addr,
  output logic [1:0] o_fetch_target,
  output logic [15:0] o_fetch_phys,
  output logic o_fetch_err,
  // data reads
  input wire logic i_rd1,
  input wire logic [15:0] i_rd1_addr,
  input wire logic i_rd2,
  input wire logic [15:0] i_rd2_addr,
  input wire logic [2:0] i_rd2_ptr,
  input wire logic i_rd2_wr,
  output logic o_dual_ok,
  output logic o_dual_err,
  // peripheral move
  input wire logic i_pmove,
  input wire logic [1:0] i_pmove_reg,
  output logic o_pmove_err,
  // exceptions
  input wire logic [3:0] i_nmi,
  input wire logic i_ext_a,
  input wire logic i_ext_b,
  input wire logic [6:0] i_chan,
  output logic o_exc_valid,
  output logic [15:0] o_exc_vector,
  // mode state
  output logic [1:0] o_mode,
  output logic o_boot_submode
);
  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  always_ff @(posedge i_clk) begin
    pin_meta <= i_boot_source_pin;
    pin_sync <= pin_meta;
  end

  // ---------------------------------------------------------------
  // strap capture on reset exit
  // ---------------------------------------------------------------
  logic in_reset;
  logic strap;
  logic strap_take;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end
  assign strap_take = in_reset && !i_srst; // first edge after release
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strap <= 1'b0;
    end else if (strap_take) begin
      strap <= pin_sync;
    end
  end

  // ---------------------------------------------------------------
  // mode bits and boot submode
  // ---------------------------------------------------------------
  logic mode_bit_a;
  logic mode_bit_b;
  logic boot_sub;
  logic booted_mode0;
  logic omr_wr;
  logic [1:0] omr_new;
  assign omr_wr = i_reg_wr && (i_reg_addr == `REG_OMR);
  assign omr_new = {i_reg_wdata[1], i_reg_wdata[0]};

  // mode write changes map only, unsupported pairs are ignored
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_bit_a <= 1'b0;
      mode_bit_b <= 1'b0;
    end else if (strap_take) begin
      mode_bit_a <= pin_sync;
      mode_bit_b <= pin_sync;
    end else if (i_wd_reset) begin
      mode_bit_a <= strap;
      mode_bit_b <= strap;
    end else if (omr_wr && omr_new[0] == omr_new[1]) begin
      mode_bit_a <= omr_new[0];
      mode_bit_b <= omr_new[1];
    end
  end

  // boot submode entered on low strap, left by a software write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      boot_sub <= 1'b0;
      booted_mode0 <= 1'b0;
    end else if (strap_take) begin
      boot_sub <= !pin_sync;
      booted_mode0 <= !pin_sync;
    end else if (i_wd_reset) begin
      boot_sub <= !strap;
    end else if (omr_wr) begin
      boot_sub <= i_reg_wdata[2] && booted_mode0;
    end
  end

  // ---------------------------------------------------------------
  // registered fetch map, live one cycle after a mode write
  // ---------------------------------------------------------------
  logic mode3;
  logic next_err;
  logic [1:0] next_tgt;
  logic [15:0] next_phys;
  assign mode3 = mode_bit_a && mode_bit_b;
  // mode 3 wins over everything, so no internal word is fetched there
  // vector words 0..3 alias into boot flash ahead of any submode test
  always_comb begin
    next_tgt = opmode_pkg::TGT_NONE;
    next_phys = i_fetch_addr;
    next_err = 1'b0;
    if (!i_fetch || in_reset) begin
      next_tgt = opmode_pkg::TGT_NONE;
    end else if (mode3) begin
      next_tgt = opmode_pkg::TGT_EXTERNAL;
    end else if (i_fetch_addr <= `BOOT_ALIAS_LAST) begin
      next_tgt = opmode_pkg::TGT_BOOT;
      next_phys = `BOOT_BASE | i_fetch_addr;
    end else if (boot_sub) begin
      if (i_fetch_addr >= `BOOT_BASE && i_fetch_addr <= `BOOT_LAST) begin
        next_tgt = opmode_pkg::TGT_BOOT;
      end else begin
        next_tgt = opmode_pkg::TGT_INTERNAL;
      end
    end else if (i_fetch_addr <= `INT_HALF_LAST) begin
      next_tgt = opmode_pkg::TGT_INTERNAL;
    end else begin
      next_tgt = opmode_pkg::TGT_EXTERNAL;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_fetch_target <= 2'h0;
      o_fetch_phys <= 16'h0000;
      o_fetch_err <= 1'b0;
    end else begin
      o_fetch_target <= next_tgt;
      o_fetch_phys <= next_phys;
      o_fetch_err <= next_err; // program space never reaches data ram
    end
  end

  // ---------------------------------------------------------------
  // dual data read checks
  // ---------------------------------------------------------------
  function automatic logic [1:0] data_kind(input logic [15:0] a);
    if (a <= `DATA_RAM_LAST) begin
      data_kind = opmode_pkg::DTGT_RAM;
    end else if (a >= `DATA_FLASH_BASE && a <= `DATA_FLASH_LAST) begin
      data_kind = opmode_pkg::DTGT_FLASH;
    end else begin
      data_kind = opmode_pkg::DTGT_OTHER;
    end
  endfunction : data_kind
  logic both_flash;
  logic bad_path2;
  assign both_flash = i_rd1 && i_rd2
    && data_kind(i_rd1_addr) == opmode_pkg::DTGT_FLASH
    && data_kind(i_rd2_addr) == opmode_pkg::DTGT_FLASH;
  assign bad_path2 = i_rd2 && (i_rd2_wr || !i_rd1
    || i_rd2_ptr != `PTR_THREE);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dual_ok <= 1'b0;
      o_dual_err <= 1'b0;
    end else begin
      o_dual_ok <= i_rd1 && i_rd2 && !both_flash && !bad_path2;
      o_dual_err <= both_flash || bad_path2;
    end
  end

  // ---------------------------------------------------------------
  // peripheral moves and core registers
  // ---------------------------------------------------------------
  logic [15:0] interrupt_priority_register;
  logic [15:0] busctl;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pmove_err <= 1'b0;
    end else begin
      o_pmove_err <= i_pmove && (i_pmove_reg == `REG_STATUS);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      interrupt_priority_register <= 16'h0000;
      busctl <= 16'h0000;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `REG_IPR) begin
        interrupt_priority_register <= i_reg_wdata;
      end
      if (i_reg_addr == `REG_BUSCTL) begin
        busctl <= i_reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_OMR: o_reg_rdata <= {13'h0000, boot_sub, mode_bit_b, mode_bit_a};
        `REG_STATUS: o_reg_rdata <= {14'h0000, booted_mode0, strap};
        `REG_IPR: o_reg_rdata <= interrupt_priority_register;
        `REG_BUSCTL: o_reg_rdata <= busctl;
        default: o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // exception arbiter and outputs
  // ---------------------------------------------------------------
  exception_arbiter u_arb (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_hw_reset(in_reset),
    .i_wd_reset(i_wd_reset),
    .i_nmi(i_nmi),
    .i_ext_a(i_ext_a),
    .i_ext_b(i_ext_b),
    .i_chan(i_chan),
    .i_ipr(interrupt_priority_register),
    .o_valid(o_exc_valid),
    .o_vector(o_exc_vector)
  );
  assign o_mode = {mode_bit_b, mode_bit_a};
  assign o_boot_submode = boot_sub;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // strap sets both mode bits and the boot submode on reset exit
  a_strap_mode: assert property (@(posedge i_clk) disable iff (i_srst)
    strap_take |=> o_mode == {2{$past(pin_sync)}})
    else $error("mode not taken from strap");
  a_boot_entry: assert property (@(posedge i_clk) disable iff (i_srst)
    strap_take |=> o_boot_submode == !$past(pin_sync))
    else $error("boot submode not taken from strap");
  a_mode_legal: assert property (@(posedge i_clk) disable iff (i_srst)
    o_mode == 2'h0 || o_mode == 2'h3)
    else $error("unsupported mode entered");
  a_wd_restore: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_wd_reset && !strap_take) |=> o_mode == {2{strap}})
    else $error("watchdog did not restore mode");
  a_mode_write: assert property (@(posedge i_clk) disable iff (i_srst)
    (omr_wr && !strap_take && !i_wd_reset && i_reg_wdata[1:0] == 2'h3)
    |=> o_mode == 2'h3)
    else $error("mode write lost");
  a_boot_locked: assert property (@(posedge i_clk) disable iff (i_srst)
    (omr_wr && !booted_mode0 && !strap_take && !i_wd_reset)
    |=> !o_boot_submode)
    else $error("boot submode after external boot");
  // fetch map for mode 3, the vector alias in mode 0, and mode 0 outside the boot submode
  a_ext_all: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode3 && i_fetch && !in_reset) |=>
    o_fetch_target == opmode_pkg::TGT_EXTERNAL)
    else $error("mode 3 fetch not external");
  a_ext_vector: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode3 && i_fetch && !in_reset)
    |=> o_fetch_phys == $past(i_fetch_addr))
    else $error("external address altered");
  a_alias_boot: assert property (@(posedge i_clk) disable iff (i_srst)
    (!mode3 && i_fetch && !in_reset && i_fetch_addr == `VEC_WD_RESET)
    |=> o_fetch_phys == (`BOOT_BASE | `VEC_WD_RESET))
    else $error("vector alias missing");
  a_upper_ext: assert property (@(posedge i_clk) disable iff (i_srst)
    (!mode3 && !boot_sub && i_fetch && !in_reset && i_fetch_addr[15])
    |=> o_fetch_target == opmode_pkg::TGT_EXTERNAL)
    else $error("upper half not external");
  a_lower_int: assert property (@(posedge i_clk) disable iff (i_srst)
    (!mode3 && !boot_sub && i_fetch && !in_reset && !i_fetch_addr[15]
     && i_fetch_addr > `BOOT_ALIAS_LAST)
    |=> o_fetch_target == opmode_pkg::TGT_INTERNAL)
    else $error("lower half not internal");
  a_remap_time: assert property (@(posedge i_clk) disable iff (i_srst)
    (omr_wr && !strap_take && !i_wd_reset && i_reg_wdata[1:0] == 2'h3)
    ##1 (i_fetch && !in_reset) |=>
    o_fetch_target == opmode_pkg::TGT_EXTERNAL)
    else $error("remap late");
  // data read pairing and peripheral moves
  a_flash_pair: assert property (@(posedge i_clk) disable iff (i_srst)
    both_flash |=> o_dual_err && !o_dual_ok)
    else $error("dual flash read allowed");
  a_path2_ptr: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd2 && i_rd2_ptr != `PTR_THREE) |=> o_dual_err && !o_dual_ok)
    else $error("second path pointer accepted");
  a_pmove_core: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_pmove && i_pmove_reg != `REG_STATUS) |=> !o_pmove_err)
    else $error("core register move refused");
endmodule : opmode_memory_map
`default_nettype wire

// ===== design/opmode_params.svh
// constants for the operating mode and memory map block
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH
`define PADDR_W 16
`define DADDR_W 16
`define VEC_HW_RESET 16'h0000
`define VEC_WD_RESET 16'h0002
`define VEC_RSVD_A 16'h0004
`define VEC_ILLEGAL 16'h0006
`define VEC_SWI 16'h0008
`define VEC_STACK 16'h000a
`define VEC_EMU 16'h000c
`define VEC_RSVD_B 16'h000e
`define VEC_EXT_A 16'h0010
`define VEC_EXT_B 16'h0012
`define VEC_PERIPH_BASE 16'h0014
`define VEC_PERIPH_LAST 16'h007e
`define BOOT_BASE 16'h8000
`define BOOT_LAST 16'h87ff
`define BOOT_ALIAS_LAST 16'h0003
`define INT_HALF_LAST 16'h7fff
`define DATA_RAM_BASE 16'h0000
`define DATA_RAM_LAST 16'h07ff
`define DATA_FLASH_BASE 16'h1000
`define DATA_FLASH_LAST 16'h1fff
`define PTR_THREE 3'h3
`define MODE_REMAP_FETCHES 2
`define REG_OMR 2'h0
`define REG_STATUS 2'h1
`define REG_IPR 2'h2
`define REG_BUSCTL 2'h3
`endif

// ===== design/opmode_pkg.sv
// types for the operating mode and memory map block
package opmode_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_RSVD1 = 2'h1,
    MODE_RSVD2 = 2'h2,
    MODE_EXT = 2'h3
  } chip_mode_t;
  typedef enum logic [1:0] {
    TGT_NONE, TGT_INTERNAL, TGT_EXTERNAL, TGT_BOOT
  } target_t;
  typedef enum logic [1:0] {
    DTGT_NONE, DTGT_RAM, DTGT_FLASH, DTGT_OTHER
  } dtarget_t;
endpackage : opmode_pkg

// ===== dv/ext_prog_mem.sv
// external program memory model seen by the fetch path
`timescale 1ns/1ps
`default_nettype none
module ext_prog_mem #(
  parameter logic [15:0] JUMP_WORD = 16'h0e40 // arbitrary opcode value
) (
  // clock
  input wire logic i_clk,
  // access
  input wire logic i_sel,
  input wire logic [15:0] i_addr,
  output logic [15:0] o_data
);
  logic [15:0] last;
  logic rst_vec;
  // reset vector words hold a jump, other words echo their address
  assign rst_vec = (i_addr == 16'h0000) || (i_addr == 16'h0002);
  assign o_data = i_sel ? (rst_vec ? JUMP_WORD : i_addr) : ~last;
  // released bus shows the inverse of the last word, toggling each cycle
  always_ff @(posedge i_clk) begin
    last <= o_data;
  end
endmodule : ext_prog_mem
`default_nettype wire

// ===== dv/operating_mode_memory_map_tb_top.sv
// self-checking testbench for the operating mode and memory map block
`timescale 1ns/1ps
`default_nettype none
`include "opmode_params.svh"
module operating_mode_memory_map_tb_top;
  localparam logic [15:0] JUMP = 16'h0e40; // arbitrary opcode value
  localparam int LOAD_N = 3; // code words, below the target area size
  logic clk = 1'b0, srst = 1'b1, wd = 1'b0, pin = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, fetch = 1'b0, fetch_err;
  logic [15:0] fetch_addr = 16'h0, fetch_phys, mem_data;
  logic [1:0] fetch_target, mode, pmove_reg = 2'h0;
  logic rd1 = 1'b0, rd2 = 1'b0, rd2_wr = 1'b0, dual_ok, dual_err;
  logic [15:0] rd1_addr = 16'h0, rd2_addr = 16'h0, exc_vector;
  logic [2:0] rd2_ptr = 3'h3;
  logic pmove = 1'b0, pmove_err, ext_a = 1'b0, ext_b = 1'b0;
  logic [3:0] nmi = 4'h0;
  logic [6:0] chan = 7'h0;
  logic exc_valid, boot_sub;
  int errors = 0, tests_run = 0;
  // ----------------------------------------------------------------
  // clock and instances
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  opmode_memory_map dut_u (.i_clk(clk), .i_srst(srst), .i_wd_reset(wd),
    .i_boot_source_pin(pin), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_fetch(fetch), .i_fetch_addr(fetch_addr), .o_fetch_target(fetch_target),
    .o_fetch_phys(fetch_phys), .o_fetch_err(fetch_err), .i_rd1(rd1),
    .i_rd1_addr(rd1_addr), .i_rd2(rd2), .i_rd2_addr(rd2_addr),
    .i_rd2_ptr(rd2_ptr), .i_rd2_wr(rd2_wr), .o_dual_ok(dual_ok),
    .o_dual_err(dual_err), .i_pmove(pmove), .i_pmove_reg(pmove_reg),
    .o_pmove_err(pmove_err), .i_nmi(nmi), .i_ext_a(ext_a), .i_ext_b(ext_b),
    .i_chan(chan), .o_exc_valid(exc_valid), .o_exc_vector(exc_vector),
    .o_mode(mode), .o_boot_submode(boot_sub));
  ext_prog_mem #(.JUMP_WORD(JUMP)) mem_u (.i_clk(clk),
    .i_sel(fetch_target == opmode_pkg::TGT_EXTERNAL),
    .i_addr(fetch_phys), .o_data(mem_data));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // strap set with reset, two reset edges, synced before release
  task automatic do_reset(input logic strap);
    srst <= 1'b1;
    pin <= strap;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // mode write with the next fetch in the very next cycle
  task automatic write_fetch(input logic [15:0] d, input logic [15:0] a,
                             input logic [1:0] tgt);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= `REG_OMR;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    fetch <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch <= 1'b0;
    #1 chk("early fetch target", {14'h0, tgt}, {14'h0, fetch_target});
  endtask : write_fetch
  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("register read", exp, reg_rdata);
  endtask : reg_read
  task automatic do_fetch(input logic [15:0] a, input logic [1:0] tgt,
                          input logic [15:0] phys);
    @(posedge clk);
    fetch <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch <= 1'b0;
    #1 chk("fetch target", {14'h0, tgt}, {14'h0, fetch_target});
    chk("fetch address", phys, fetch_phys);
    chk("fetch error", 16'h0, {15'h0, fetch_err});
  endtask : do_fetch
  task automatic exc(input logic [3:0] n, input logic a, input logic b,
                     input logic [6:0] c, input logic [15:0] exp);
    @(posedge clk);
    nmi <= n;
    ext_a <= a;
    ext_b <= b;
    chan <= c;
    @(posedge clk);
    #1 chk("exception valid", 16'h0001, {15'h0, exc_valid});
    chk("exception vector", exp, exc_vector);
    @(posedge clk);
    {nmi, ext_a, ext_b, chan} <= '0;
  endtask : exc
  task automatic dual(input logic [15:0] a1, input logic [15:0] a2,
                      input logic [2:0] p, input logic w, input logic bad);
    @(posedge clk);
    {rd1, rd2, rd1_addr, rd2_addr, rd2_ptr, rd2_wr} <= {2'b11, a1, a2, p, w};
    @(posedge clk);
    {rd1, rd2, rd2_wr} <= 3'b000;
    #1 chk("dual read", {14'h0, ~bad, bad}, {14'h0, dual_ok, dual_err});
  endtask : dual
  // ----------------------------------------------------------------
  // watchdog against a hang
  // ----------------------------------------------------------------
  initial begin
    #50us;
    errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] nvec [4];
    nvec = '{`VEC_ILLEGAL, `VEC_STACK, `VEC_EMU, `VEC_SWI};
    do_reset(1'b0);
    chk("mode after strap low", 16'h4, {13'h0, boot_sub, mode});
    do_fetch(16'h0002, opmode_pkg::TGT_BOOT, 16'h8002);
    do_fetch(16'h0000, opmode_pkg::TGT_BOOT, 16'h8000);
    do_fetch(16'h87ff, opmode_pkg::TGT_BOOT, 16'h87ff);
    // requests stay quiet and one idle cycle follows the mode write
    reg_write(`REG_OMR, 16'h0000);
    do_fetch(16'h7fff, opmode_pkg::TGT_INTERNAL, 16'h7fff);
    do_fetch(16'h9000, opmode_pkg::TGT_EXTERNAL, 16'h9000);
    $display("test boot map done");
    write_fetch(16'h0003, 16'h0002, opmode_pkg::TGT_EXTERNAL);
    do_fetch(16'h0002, opmode_pkg::TGT_EXTERNAL, 16'h0002);
    chk("reset vector word", JUMP, mem_data);
    do_fetch(16'h1234, opmode_pkg::TGT_EXTERNAL, 16'h1234);
    reg_write(`REG_OMR, 16'h0001);
    reg_write(`REG_OMR, 16'h0002);
    reg_read(`REG_OMR, 16'h0003);
    @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    wd <= 1'b0;
    #1 chk("watchdog vector", `VEC_WD_RESET, exc_vector);
    chk("mode after watchdog", 16'h0, {14'h0, mode});
    $display("test mode writes done");
    reg_write(`REG_IPR, 16'hfe09);
    reg_read(`REG_IPR, 16'hfe09);
    reg_write(`REG_BUSCTL, 16'h00a5);
    reg_read(`REG_BUSCTL, 16'h00a5);
    for (int k = 0; k < 4; k++) begin
      exc(4'hf << k, 1'b1, 1'b1, 7'h7f, nvec[k]);
    end
    exc(4'h0, 1'b1, 1'b1, 7'h7f, `VEC_EXT_A);
    exc(4'h0, 1'b0, 1'b1, 7'h7f, `VEC_EXT_B);
    for (int c = 0; c < 7; c++) begin
      exc(4'h0, 1'b0, 1'b0, 7'h7f >> (6 - c), 16'h0014 + 16'(2 * c));
    end
    $display("test exceptions done");
    dual(16'h1000, 16'h1800, 3'h3, 1'b0, 1'b1);
    dual(16'h0010, 16'h1800, 3'h3, 1'b0, 1'b0);
    dual(16'h1000, 16'h07ff, 3'h3, 1'b0, 1'b0);
    dual(16'h0010, 16'h0020, 3'h2, 1'b0, 1'b1);
    dual(16'h0010, 16'h0020, 3'h3, 1'b1, 1'b1);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      pmove <= 1'b1;
      pmove_reg <= 2'(r);
      @(posedge clk);
      pmove <= 1'b0;
      #1 chk("peripheral move", 16'(r == 1), {15'h0, pmove_err});
    end
    $display("test data paths done");
    @(posedge clk);
    do_reset(1'b1);
    chk("mode after strap high", 16'h3, {13'h0, boot_sub, mode});
    reg_read(`REG_STATUS, 16'h0001);
    do_fetch(16'h0000, opmode_pkg::TGT_EXTERNAL, 16'h0000);
    reg_write(`REG_OMR, 16'h0007);
    reg_read(`REG_OMR, 16'h0003);
    // load stream: count word, start address, then the code words
    for (int k = 0; k < LOAD_N + 2; k++) begin
      do_fetch(16'h0100 + 16'(k), opmode_pkg::TGT_EXTERNAL,
               16'h0100 + 16'(k));
      chk("load stream word", 16'h0100 + 16'(k), mem_data);
    end
    $display("test external boot done");
    end_sim();
  end
endmodule : operating_mode_memory_map_tb_top
`default_nettype wire
